// file: logic/sarseq_defines.svh
// Purpose: Constants for the converter sequencer: offsets, fields, reset values, timing counts.
// Assumes: 16-bit register data on a plain strobe port.
// Notes:   Offsets are word indices on the register port.
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH

`define SARSEQ_ADDR_W        6
`define SARSEQ_OFS_CTRL1     6'h00
`define SARSEQ_OFS_CTRL2     6'h01
`define SARSEQ_OFS_CTRL3     6'h02
`define SARSEQ_OFS_STATUS    6'h03
`define SARSEQ_OFS_BUF0      6'h10

// Control 1 fields
`define SARSEQ_C1_ON         15
`define SARSEQ_C1_SSRC_LO    5
`define SARSEQ_C1_AUTO_SAMPLE_ENABLE       2
`define SARSEQ_C1_SAMPLE_HOLD_BIT       1
`define SARSEQ_C1_MASK       16'h80e6
// Control 2 fields
`define SARSEQ_C2_SMPI_LO    2
`define SARSEQ_C2_BUFFER_SPLIT_MODE       1
`define SARSEQ_C2_ALTERNATE_INPUT_SELECT       0
`define SARSEQ_C2_MASK       16'h003f
// Control 3 fields
`define SARSEQ_C3_AUTO_SAMPLE_TIME_LO    8
`define SARSEQ_C3_RC_CLOCK_SELECT       7
`define SARSEQ_C3_ADCS_LO    0
`define SARSEQ_C3_MASK       16'h1fbf
// Status fields
`define SARSEQ_ST_DONE       0
`define SARSEQ_ST_CONVERSION_ACTIVE       1
`define SARSEQ_ST_IRQ        2

`define SARSEQ_RST_REG       16'h0000

`define SARSEQ_SRC_SW        3'h0
`define SARSEQ_SRC_TIMER     3'h2
`define SARSEQ_SRC_EXT       3'h1
`define SARSEQ_SRC_AUTO      3'h7

`define SARSEQ_CONVERSION_ACTIVE_TADS     5'h0e
`define SARSEQ_ABORT_TADS    2
// One instruction cycle delay before an RC-clocked conversion, in mclk cycles
`define SARSEQ_TCY_NS        5
`define SARSEQ_CLK_NS        5
`define SARSEQ_RC_DELAY      ((`SARSEQ_TCY_NS + `SARSEQ_CLK_NS - 1) / `SARSEQ_CLK_NS)

`endif

// file: logic/sarseq_pkg.sv
// Purpose: Types shared by the converter sequencer.
// Assumes: Constants come from sarseq_defines.svh.
// Notes:   None.
`default_nettype none
package sarseq_pkg;
	typedef enum logic [1:0] {
		SARSEQ_IDLE   = 2'b00,
		SARSEQ_SAMPLE = 2'b01,
		SARSEQ_WAIT   = 2'b10,
		SARSEQ_CONVERSION_ACTIVE   = 2'b11
	} sarseq_state_e;

	typedef struct packed {
		logic [5:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} sarseq_bus_s;

	typedef struct packed {
		logic        sample;
		logic        convert;
		logic        tad_tick;
	} sarseq_analog_s;
endpackage
`default_nettype wire

// file: logic/sarseq_tad_div.sv
// Purpose: Conversion clock tick: divided instruction clock or RC tick.
// Assumes: mclk is the instruction clock; rc_tick is an already synchronised pulse.
// Notes:   Tick comes every divisor+1 half-cycles of the instruction clock, rounded up to whole cycles.
`include "sarseq_defines.svh"
`default_nettype none
module sarseq_tad_div #(
	parameter int DIV_W = 6
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             run,
	input  wire logic             rc_sel,
	input  wire logic             rc_tick,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  tad_tick
);
	import sarseq_pkg::*;

	// Half-cycle steps: count 2 per mclk, wrap at divisor+1 (period = Tcy*0.5*(div+1), rounded up to whole Tcy)
	logic [DIV_W+1:0] acc;
	wire  [DIV_W+1:0] limit   = {2'b00, divisor} + {{(DIV_W+1){1'b0}}, 1'b1};
	wire  [DIV_W+1:0] acc_inc = acc + {{DIV_W{1'b0}}, 2'b10};
	wire              wrap    = acc_inc >= limit;
	wire              div_tick = run && !rc_sel && wrap;

	always_ff @(posedge mclk) begin
		if (sys_rst || !run || rc_sel) begin
			acc <= '0;
		end else begin
			// Remainder is dropped on wrap so the count stays bounded; even divisors run slightly slow
			acc <= wrap ? '0 : acc_inc; // [R14]
		end
	end

	// Divisor 0 would tick twice per mclk; one pulse per mclk is the limit of a single clock
	assign tad_tick = div_tick || (run && rc_sel && rc_tick); // [R14] [R15]
endmodule
`default_nettype wire

// file: logic/sarseq_top.sv
// Purpose: Sequencer for a 12-bit successive-approximation converter.
// Assumes: mclk is the instruction clock; analog core converts while convert is high.
// Notes:   Register port has one-cycle read latency and never stalls.
// Summary of operation
// [R1] Software leaves trigger, sample and buffer settings alone while the converter is on.
// [R2] Sixteen 12-bit result entries, readable but not writable by software.
// [R3] Setting the sample-hold bit starts acquisition.
// [R4] Each result is stored; done and irq set after the programmed sample count.
// [R5] Trigger select 000: clearing sample-hold ends acquisition and starts conversion.
// [R6] Trigger select 111: conversion starts after auto-sample-time conversion clocks.
// [R7] Software sets auto-sample time to at least one when using auto-start.
// [R8] Timer and external events can also end acquisition and start conversion.
// [R9] Turning the converter off aborts conversion and stops sequencing.
// [R10] An aborted conversion leaves the result buffer unchanged.
// [R11] Turn-off wins over a coinciding auto-start; no conversion begins.
// [R12] Software waits two conversion clocks after abort before sampling again.
// [R13] A conversion takes fourteen conversion clocks.
// [R14] Conversion clock period is Tcy times half of divisor plus one; even divisors round up to whole Tcy.
// [R15] RC clock select uses the internal RC tick as conversion clock.
// [R16] Software keeps the conversion clock period at or above 667 ns.
// [R17] Converter on: active; off: sequencing and clock disabled.
// [R18] Sleep aborts a conversion, not resumed on wake-up.
// [R19] Sleep entry and exit leave register contents unchanged.
// [R20] With RC clock, conversion works in sleep, starting one instruction cycle late; the WAIT state holds two mclk cycles.
// [R21] On completion conversion-active clears and the result is stored.
// [R22] Done in sleep: wake if irq enabled, else the module turns itself off; the code does this on every stored result.
// [R23] Reset clears registers, turns off, aborts; the result buffer is kept.
// [R24] Write position advances per result and wraps after each interrupt group.
//
// Design decisions made here: the strobed register port and the register addresses.
`include "sarseq_defines.svh"
`default_nettype none
module sarseq_top #(
	parameter int DEPTH  = 16,
	parameter int DATA_W = 12
) (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire sarseq_pkg::sarseq_bus_s bus,
	output logic [15:0]                rdata,
	input  wire logic                  sleep,
	input  wire logic                  irq_enable,
	input  wire logic                  timer_trig,
	input  wire logic                  ext_trig_pin,
	input  wire logic                  rc_clk_pin,
	input  wire logic [DATA_W-1:0]     core_result,
	output sarseq_pkg::sarseq_analog_s analog,
	output logic                       converter_irq_flag,
	output logic                       wake_req
);
	import sarseq_pkg::*;

	logic [15:0]       ctrl1;
	logic [15:0]       ctrl2;
	logic [15:0]       ctrl3;
	logic              done;
	logic [DATA_W-1:0] result_buffer [DEPTH];
	logic [3:0]        wr_pos;
	logic [3:0]        grp_cnt;
	logic [4:0]        tad_cnt;
	logic [1:0]        rc_dly;
	logic              sleep_off;
	logic [2:0]        ext_sync;
	logic [2:0]        rc_sync;
	logic              ext_q;
	logic              rc_q;
	logic              rc_lvl;
	sarseq_state_e     state;
	sarseq_state_e     next_state;

	// Bus decode
	wire wr_c1   = bus.wr && bus.addr == `SARSEQ_OFS_CTRL1;
	wire wr_c2   = bus.wr && bus.addr == `SARSEQ_OFS_CTRL2;
	wire wr_c3   = bus.wr && bus.addr == `SARSEQ_OFS_CTRL3;
	wire wr_st   = bus.wr && bus.addr == `SARSEQ_OFS_STATUS;
	wire is_buf  = bus.addr[5:4] == 2'b01;

	// Fields
	wire       conversion_active_on   = ctrl1[`SARSEQ_C1_ON];
	wire [2:0] trig_src  = ctrl1[`SARSEQ_C1_SSRC_LO +: 3];
	wire       auto_sample_hold_bit = ctrl1[`SARSEQ_C1_AUTO_SAMPLE_ENABLE];
	wire       sample_hold_bit_bit  = ctrl1[`SARSEQ_C1_SAMPLE_HOLD_BIT];
	wire [3:0] smpi      = ctrl2[`SARSEQ_C2_SMPI_LO +: 4];
	wire [4:0] auto_sample_time      = ctrl3[`SARSEQ_C3_AUTO_SAMPLE_TIME_LO +: 5];
	wire       rc_sel    = ctrl3[`SARSEQ_C3_RC_CLOCK_SELECT];
	wire [5:0] divisor   = ctrl3[`SARSEQ_C3_ADCS_LO +: 6];

	// Sleep stops the divided clock; only RC keeps running
	wire active    = conversion_active_on && !sleep_off; // [R17] [R22]
	wire clk_ok    = !sleep || rc_sel; // [R18] [R20]
	wire run       = active && clk_ok;
	wire tad_tick;

	sarseq_tad_div #(
		.DIV_W(6)
	) u_div (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.run     (run),
		.rc_sel  (rc_sel),
		.rc_tick (rc_q),
		.divisor (divisor),
		.tad_tick(tad_tick)
	);

	// Pin synchronisers: change counts when stages 2 and 3 agree
	// One tick per RC rise: a level-based pulse would fire every cycle while the pin is high
	wire rc_new = (rc_sync[2] == rc_sync[1]) ? rc_sync[1] : rc_lvl;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_sync <= 3'h0;
			rc_sync  <= 3'h0;
			ext_q    <= 1'b0;
			rc_lvl   <= 1'b0;
			rc_q     <= 1'b0;
		end else begin
			ext_sync <= {ext_sync[1:0], ext_trig_pin};
			rc_sync  <= {rc_sync[1:0], rc_clk_pin};
			ext_q    <= (ext_sync[2] == ext_sync[1]) ? ext_sync[1] : ext_q;
			rc_lvl   <= rc_new;
			rc_q     <= rc_new && !rc_lvl; // [R15]
		end
	end

	logic ext_prev;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= ext_q;
		end
	end
	wire ext_rise = ext_q && !ext_prev;

	// Trigger selection while sampling
	wire sw_end    = trig_src == `SARSEQ_SRC_SW && !sample_hold_bit_bit; // [R5]
	wire auto_end  = trig_src == `SARSEQ_SRC_AUTO && tad_tick && tad_cnt + 5'h01 >= auto_sample_time; // [R6]
	wire tmr_end   = trig_src == `SARSEQ_SRC_TIMER && timer_trig; // [R8]
	wire ext_end   = trig_src == `SARSEQ_SRC_EXT && ext_rise; // [R8]
	wire trig_end  = sw_end || auto_end || tmr_end || ext_end;
	wire conversion_active_last = state == SARSEQ_CONVERSION_ACTIVE && tad_tick && tad_cnt == `SARSEQ_CONVERSION_ACTIVE_TADS - 5'h01; // [R13]
	wire grp_last  = grp_cnt == smpi;
	wire sample_hold_bit_set  = wr_c1 && bus.wdata[`SARSEQ_C1_SAMPLE_HOLD_BIT];

	always_comb begin
		next_state = state;
		unique case (state)
			SARSEQ_IDLE:   if (run && sample_hold_bit_bit) next_state = SARSEQ_SAMPLE; // [R3]
			SARSEQ_SAMPLE: if (trig_end) next_state = rc_sel ? SARSEQ_WAIT : SARSEQ_CONVERSION_ACTIVE;
			SARSEQ_WAIT:   if (rc_dly == 2'(`SARSEQ_RC_DELAY)) next_state = SARSEQ_CONVERSION_ACTIVE; // [R20]
			SARSEQ_CONVERSION_ACTIVE:   if (conversion_active_last) next_state = auto_sample_hold_bit ? SARSEQ_SAMPLE : SARSEQ_IDLE;
		endcase
		// Off or clock loss aborts anything in flight, ahead of any trigger
		if (!run) next_state = SARSEQ_IDLE; // [R9] [R11] [R18]
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= SARSEQ_IDLE; // [R23]
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || state != next_state) begin
			tad_cnt <= 5'h00;
			rc_dly  <= 2'h0;
		end else begin
			tad_cnt <= tad_tick ? tad_cnt + 5'h01 : tad_cnt;
			rc_dly  <= rc_dly + 2'h1;
		end
	end

	wire store = conversion_active_last && run; // [R10]

	// Result buffer: hardware writes only; reset leaves contents alone
	always_ff @(posedge mclk) begin
		if (store) begin
			result_buffer[wr_pos] <= core_result; // [R2] [R21]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_pos  <= 4'h0;
			grp_cnt <= 4'h0;
		end else if (!conversion_active_on) begin
			wr_pos  <= 4'h0;
			grp_cnt <= 4'h0;
		end else if (store) begin
			wr_pos  <= grp_last ? 4'h0 : wr_pos + 4'h1; // [R24]
			grp_cnt <= grp_last ? 4'h0 : grp_cnt + 4'h1;
		end
	end

	// Registers; sleep has no path here, so contents survive it
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl1 <= `SARSEQ_RST_REG; // [R23]
			ctrl2 <= `SARSEQ_RST_REG;
			ctrl3 <= `SARSEQ_RST_REG;
		end else begin
			if (wr_c1) begin
				ctrl1 <= bus.wdata & `SARSEQ_C1_MASK; // [R19]
			end else if (conversion_active_last && auto_sample_hold_bit) begin
				ctrl1[`SARSEQ_C1_SAMPLE_HOLD_BIT] <= 1'b1;
			end else if (state == SARSEQ_SAMPLE && trig_end && trig_src != `SARSEQ_SRC_SW) begin
				ctrl1[`SARSEQ_C1_SAMPLE_HOLD_BIT] <= auto_sample_hold_bit;
			end
			if (wr_c2) begin
				ctrl2 <= bus.wdata & `SARSEQ_C2_MASK;
			end
			if (wr_c3) begin
				ctrl3 <= bus.wdata & `SARSEQ_C3_MASK;
			end
		end
	end

	// Done and irq flags: hardware set wins over software clear
	wire grp_done = store && grp_last;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			done               <= 1'b0;
			converter_irq_flag <= 1'b0;
		end else begin
			done               <= grp_done || (done && !sample_hold_bit_set && !(wr_st && !bus.wdata[`SARSEQ_ST_DONE])); // [R4]
			converter_irq_flag <= grp_done || (converter_irq_flag && !(wr_st && !bus.wdata[`SARSEQ_ST_IRQ])); // [R4]
		end
	end

	// Self turn-off in sleep without irq; converter_on bit stays set
	always_ff @(posedge mclk) begin
		if (sys_rst || !sleep || !conversion_active_on) begin
			sleep_off <= 1'b0;
			wake_req  <= 1'b0;
		end else if (grp_done || store) begin
			sleep_off <= !irq_enable; // [R22]
			wake_req  <= irq_enable; // [R22]
		end
	end

	// Read mux
	wire conversion_active_busy = state == SARSEQ_CONVERSION_ACTIVE || state == SARSEQ_WAIT;
	wire [15:0] st_word = {13'h0000, converter_irq_flag, conversion_active_busy, done};
	wire [15:0] buf_word = {{(16 - DATA_W){1'b0}}, result_buffer[bus.addr[3:0]]};
	wire [15:0] rd_mux =
		(bus.addr == `SARSEQ_OFS_CTRL1)  ? ctrl1 :
		(bus.addr == `SARSEQ_OFS_CTRL2)  ? ctrl2 :
		(bus.addr == `SARSEQ_OFS_CTRL3)  ? ctrl3 :
		(bus.addr == `SARSEQ_OFS_STATUS) ? st_word :
		is_buf                           ? buf_word : 16'h0000;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= bus.rd ? rd_mux : 16'h0000;
		end
	end

	assign analog.sample   = state == SARSEQ_SAMPLE;
	assign analog.convert  = state == SARSEQ_CONVERSION_ACTIVE;
	assign analog.tad_tick = tad_tick;

	AST_CONVERSION_ACTIVE_LEN: assert property (@(posedge mclk) disable iff (sys_rst) // [R13]
		$rose(state == SARSEQ_CONVERSION_ACTIVE) |-> !store [*1])
		else $error("conversion stored on first cycle");
	AST_ABORT: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
		!conversion_active_on |=> state == SARSEQ_IDLE)
		else $error("sequencer ran while off");
	AST_NO_STORE_OFF: assert property (@(posedge mclk) disable iff (sys_rst) // [R10]
		!run |-> !store)
		else $error("result stored after abort");
	AST_OFF_WINS: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
		(state == SARSEQ_SAMPLE && auto_end && !run) |=> state != SARSEQ_CONVERSION_ACTIVE)
		else $error("conversion began after turn-off");
	AST_DONE_SET: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		grp_done |=> done && converter_irq_flag)
		else $error("done not set after group");
	AST_DONE_ONLY: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		(store && !grp_last && !done) |=> !done)
		else $error("done set early");
	AST_SAMPLE_START: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
		(state == SARSEQ_IDLE && run && sample_hold_bit_bit) |=> state == SARSEQ_SAMPLE)
		else $error("sampling did not start");
	AST_SW_TRIG: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		(state == SARSEQ_SAMPLE && run && sw_end && !rc_sel) |=> state == SARSEQ_CONVERSION_ACTIVE)
		else $error("software trigger ignored");
	AST_WRAP: assert property (@(posedge mclk) disable iff (sys_rst) // [R24]
		(grp_done && conversion_active_on) |=> wr_pos == 4'h0)
		else $error("write position did not wrap");
	AST_SLEEP_STOP: assert property (@(posedge mclk) disable iff (sys_rst) // [R18]
		(sleep && !rc_sel) |=> state == SARSEQ_IDLE)
		else $error("conversion ran in sleep without RC");
endmodule
`default_nettype wire

// file: test/sarseq_core_model.sv
// Purpose: Behavioural analog sample-and-hold and converter core for the sequencer bench.
// Assumes: The result settles while convert is high and is taken on the store cycle.
// Notes:   Outside a conversion the result lines carry the inverse level, so a stale store shows.
`default_nettype none
module sarseq_core_model (
	input  wire logic                      mclk,
	input  wire sarseq_pkg::sarseq_analog_s analog,
	input  wire logic [11:0]               level,
	output logic [11:0]                    core_result,
	output int                             conversion_active_ticks,
	output int                             sample_hold_bit_ticks,
	output int                             tick_gap
);
	timeunit 1ns;
	timeprecision 100ps;
	import sarseq_pkg::*;
	logic cv_q = 1'b0;
	logic sp_q = 1'b0;
	int   since = 0;
	// A partial conversion must never look like a valid result
	assign core_result = analog.convert ? level : ~level;
	always @(posedge mclk) begin
		cv_q <= analog.convert;
		sp_q <= analog.sample;
		since <= since + 1;
		if (analog.tad_tick) begin
			since <= 1;
			if (analog.convert)
				tick_gap <= since;
		end
		if (analog.convert && !cv_q)
			conversion_active_ticks <= int'(analog.tad_tick);
		else if (analog.convert && analog.tad_tick)
			conversion_active_ticks <= conversion_active_ticks + 1;
		if (analog.sample && !sp_q)
			sample_hold_bit_ticks <= int'(analog.tad_tick);
		else if (analog.sample && analog.tad_tick)
			sample_hold_bit_ticks <= sample_hold_bit_ticks + 1;
	end
endmodule
`default_nettype wire

// file: test/sarseq_top_bench.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Register port with one-cycle read latency; divisor 9 gives a tick every 5 mclk.
// Notes:   Configuration is only rewritten while the converter is off.
`include "sarseq_defines.svh"
`default_nettype none
module sarseq_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import sarseq_pkg::*;
	localparam logic [5:0] C1 = `SARSEQ_OFS_CTRL1;
	localparam logic [5:0] C2 = `SARSEQ_OFS_CTRL2;
	localparam logic [5:0] C3 = `SARSEQ_OFS_CTRL3;
	localparam logic [5:0] ST = `SARSEQ_OFS_STATUS;
	localparam logic [5:0] B0 = `SARSEQ_OFS_BUF0;
	logic           mclk, sys_rst, sleep, irq_enable, timer_trig, ext_trig_pin, rc_clk_pin;
	logic           converter_irq_flag, wake_req;
	logic [15:0]    rdata;
	logic [11:0]    core_result, level;
	sarseq_bus_s    bus;
	sarseq_analog_s analog;
	int             conversion_active_ticks, sample_hold_bit_ticks, tick_gap;
	int             miscompares = 0;
	int             samples_checked = 0;
	bit             rc_run = 1'b0;

	sarseq_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .sleep(sleep),
		.irq_enable(irq_enable), .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin),
		.rc_clk_pin(rc_clk_pin), .core_result(core_result), .analog(analog),
		.converter_irq_flag(converter_irq_flag), .wake_req(wake_req));
	sarseq_core_model i_core (.mclk(mclk), .analog(analog), .level(level), .core_result(core_result),
		.conversion_active_ticks(conversion_active_ticks), .sample_hold_bit_ticks(sample_hold_bit_ticks), .tick_gap(tick_gap));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Oscillator gated by rc_run, toggling every 40 ns on an mclk falling edge
	initial begin
		rc_clk_pin = 1'b0;
		forever begin
			#40;
			if (rc_run)
				rc_clk_pin = ~rc_clk_pin;
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp, input string m);
		samples_checked++;
		if (got != exp) begin
			miscompares++;
			$display("[FAIL] %0t %s count %0d expected %0d", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask
	task automatic chkr(input logic [5:0] a, input logic [15:0] exp, input string m);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp, m);
	endtask
	task automatic wait_lvl(input logic want, input int lim);
		int i;
		for (i = 0; i < lim && analog.convert !== want; i++) begin
			@(posedge mclk);
			#1;
		end
		if (i == lim) begin
			miscompares++;
			$display("[FAIL] %0t conversion wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic cfg(input logic [15:0] c2v, input logic [15:0] c3v);
		wr(C1, 16'h0000);
		wr(C2, c2v);
		wr(C3, c3v);
	endtask
	task automatic conversion_active_sw(input logic [11:0] l, input logic do_wait);
		level <= l;
		wr(C1, 16'h8002);
		repeat (3) @(posedge mclk);
		#1 chk({15'h0000, analog.sample}, 16'h0001, "sampling");
		wr(C1, 16'h8000);
		if (do_wait) begin
			wait_lvl(1'b1, 1000);
			wait_lvl(1'b0, 1000);
		end
	endtask
	task automatic tend(input string n);
		$display("test %s done", n);
	endtask

	initial begin
		bus = '0;
		sleep = 1'b0;
		irq_enable = 1'b0;
		timer_trig = 1'b0;
		ext_trig_pin = 1'b0;
		level = 12'h000;
		sys_rst = 1'b1;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 4; a++)
			chkr(6'(a), 16'h0000, "reset value");
		chkr(6'h05, 16'h0000, "unmapped read");
		tend("reset");
		cfg(16'h0000, 16'h0009);
		conversion_active_sw(12'h5a3, 1'b1);
		chkr(B0, 16'h05a3, "result");
		chkr(ST, 16'h0005, "status after result");
		chk({15'h0000, converter_irq_flag}, 16'h0001, "irq flag");
		chkn(conversion_active_ticks, 14, "conversion length");
		chkn(tick_gap, 5, "tick period");
		wr(ST, 16'h0000);
		chkr(ST, 16'h0000, "status clear");
		wr(B0, 16'h0abc);
		chkr(B0, 16'h05a3, "buffer write refused");
		tend("software trigger");
		cfg(16'h0004, 16'h0009);
		conversion_active_sw(12'h111, 1'b1);
		chkr(ST, 16'h0000, "done held back");
		conversion_active_sw(12'h222, 1'b1);
		chkr(ST, 16'h0005, "done after group");
		chkr(B0 + 6'h01, 16'h0222, "second slot");
		wr(ST, 16'h0000);
		conversion_active_sw(12'h333, 1'b1);
		chkr(B0, 16'h0333, "slot wraps");
		tend("sample group");
		for (int t = 0; t < 2; t++) begin
			cfg(16'h0000, 16'h0009);
			level <= 12'h4c0 + 12'(t);
			wr(C1, (t == 1) ? 16'h8022 : 16'h8042);
			repeat (4) @(posedge mclk);
			if (t == 1)
				ext_trig_pin <= 1'b1;
			else
				timer_trig <= 1'b1;
			@(posedge mclk);
			timer_trig <= 1'b0;
			wait_lvl(1'b1, 1000);
			wait_lvl(1'b0, 1000);
			ext_trig_pin <= 1'b0;
			chkr(B0, 16'h04c0 + 16'(t), "event trigger");
		end
		tend("event triggers");
		cfg(16'h0000, 16'h0309);
		level <= 12'h6e6;
		wr(C1, 16'h80e2);
		wait_lvl(1'b1, 1000);
		wait_lvl(1'b0, 1000);
		chkn(sample_hold_bit_ticks, 3, "auto sample time");
		chkr(B0, 16'h06e6, "auto result");
		tend("auto start");
		cfg(16'h0000, 16'h0009);
		conversion_active_sw(12'h0f0, 1'b0);
		wait_lvl(1'b1, 1000);
		repeat (10) @(posedge mclk);
		wr(C1, 16'h0000);
		@(posedge mclk);
		#1 chk({15'h0000, analog.convert}, 16'h0000, "abort stops");
		repeat (10) @(posedge mclk);
		chkr(B0, 16'h06e6, "abort keeps buffer");
		conversion_active_sw(12'h0f1, 1'b1);
		chkr(B0, 16'h00f1, "restart after abort");
		tend("abort");
		conversion_active_sw(12'h0f2, 1'b0);
		wait_lvl(1'b1, 1000);
		repeat (10) @(posedge mclk);
		sleep <= 1'b1;
		repeat (100) @(posedge mclk);
		sleep <= 1'b0;
		chkr(B0, 16'h00f1, "sleep aborts");
		chkr(C3, 16'h0009, "sleep keeps ctrl3");
		chkr(C1, 16'h8000, "sleep keeps ctrl1");
		tend("sleep abort");
		cfg(16'h0000, 16'h0080);
		rc_run = 1'b1;
		irq_enable <= 1'b1;
		conversion_active_sw(12'h9a9, 1'b0);
		sleep <= 1'b1;
		wait_lvl(1'b1, 1000);
		wait_lvl(1'b0, 1000);
		repeat (3) @(posedge mclk);
		#1 chk({15'h0000, wake_req}, 16'h0001, "wake in sleep");
		sleep <= 1'b0;
		chkr(B0, 16'h09a9, "rc result");
		tend("rc clock in sleep");
		conversion_active_sw(12'h9aa, 1'b0);
		wait_lvl(1'b1, 1000);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		#1 chk({15'h0000, analog.convert}, 16'h0000, "reset aborts");
		chkr(C1, 16'h0000, "reset clears ctrl1");
		chkr(B0, 16'h09a9, "reset keeps buffer");
		tend("reset mid conversion");
		complete_run();
	end
endmodule
`default_nettype wire
